/* File: common/sar_seq_pkg.sv */
// Constants and types shared by the conversion sequencer
//
// How it works
// - Acquire with arrays on inputs while idle, at any start level
// - Start rising edge ends acquisition, begins conversion
// - Open ground switches first, then ground arrays
// - Sixteen binary weighted steps, MSB first
// - After search, form code and drop busy
// - Internal step clock times conversion, no serial clock
// - Straight binary, midscale is 0x8000
// - Over-range saturates at 0xFFFF, never wraps
// - Under-range saturates at 0x0000
// - Span compression maps 0.1 to 0.9 reference
// - Sticky clamp flag, cleared only by reading
// - Clamp flag also shown in status bits
// - Span compression off until software enables it
package sar_seq_pkg;

    // Clock period of mclk_i in picoseconds
    localparam int unsigned CLK_PERIOD_PS = 8000;
    // Least time of one conversion step in picoseconds
    localparam int unsigned STEP_TIME_PS  = 48000;
    // Step length in clock cycles, rounded up, at least one
    localparam int unsigned STEP_CYCLES   =
        (STEP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Register offsets (byte addresses)
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] RESULT_OFFSET = 8'h08;

    // Field positions
    localparam int unsigned CFG_SPAN_BIT   = 0;
    localparam int unsigned STS_OV_BIT     = 0;
    localparam int unsigned STS_BUSY_BIT   = 1;
    localparam int unsigned STS_SPAN_BIT   = 2;
    localparam int unsigned STS_CLAMP_BIT  = 3;

    // Values after reset
    localparam logic        SPAN_RESET     = 1'b0;
    localparam logic [15:0] RESULT_RESET   = 16'h0000;

    // Output codes
    localparam logic [15:0] CODE_MSB       = 16'h8000;
    localparam logic [15:0] CODE_TOP       = 16'hFFFF;
    localparam logic [15:0] CODE_BOTTOM    = 16'h0000;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_ACQUIRE = 5'h01,
        ST_OPEN    = 5'h02,
        ST_HOLD    = 5'h04,
        ST_SEARCH  = 5'h08,
        ST_DONE    = 5'h10
    } seq_state_t;

endpackage : sar_seq_pkg

/* File: verilog/sar_conversion_sequencer.sv */
// Control logic of a 16-bit successive approximation converter
`timescale 1ns/1ps
`default_nettype none

module sar_conversion_sequencer #(
    parameter int unsigned STEP_LEN = sar_seq_pkg::STEP_CYCLES
) (
    input  wire logic        mclk_i,              // System clock
    input  wire logic        rst_i,               // Async reset, high
    input  wire logic        conversion_start_i,  // Start pin, async
    input  wire logic        comparator_i,        // Comparator, async
    input  wire logic        clamp_active_i,      // Clamp on, async
    input  wire logic [7:0]  reg_addr_i,          // Register address
    input  wire logic [31:0] reg_wdata_i,         // Write data
    input  wire logic        reg_wr_i,            // Write strobe
    input  wire logic        reg_rd_i,            // Read strobe
    output logic      [31:0] reg_rdata_o,         // Read data, next cycle
    output logic             sample_switch_o,     // Arrays on inputs
    output logic             positive_ground_switch_o, // Closed when 1
    output logic             negative_ground_switch_o, // Closed when 1
    output logic      [15:0] dac_bits_o,          // Elements to reference
    output logic             span_compression_o,  // Span mode to front end
    output logic             busy_o,              // Conversion running
    output logic      [15:0] result_o,            // Last complete code
    output logic             result_valid_o,      // One-cycle new code
    output logic             overvoltage_clamp_flag_o // Sticky flag
);

    // Whole state of the block
    typedef struct packed {
        logic [2:0]              cnv_sync;   // Start pin synchroniser
        logic                    cnv_f;      // Filtered start level
        logic [2:0]              cmp_sync;   // Comparator synchroniser
        logic                    cmp_f;      // Filtered comparator
        logic [2:0]              clamp_sync; // Clamp synchroniser
        logic                    clamp_f;    // Filtered clamp level
        sar_seq_pkg::seq_state_t state;      // Sequencer state
        logic [7:0]              div_cnt;    // Step clock divider
        logic [3:0]              bit_idx;    // Bit under trial
        logic [15:0]             trial;      // Trial code on the array
        logic                    ov_sample;  // Clamp seen at sampling
        logic [15:0]             result;     // Held result
        logic                    res_valid;  // New result pulse
        logic                    ov_flag;    // Sticky clamp flag
        logic                    span;       // Span compression enable
        logic [31:0]             rdata;      // Read data register
    } regs_t;

    regs_t cur;       // Registered state
    regs_t next_cur;  // Next state

    // Filtered level: follows when stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic old);
        filt = (s[1] == s[2]) ? s[2] : old;
    endfunction : filt

    // Address decode used by read and read-clear logic
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic       step_tick;   // Internal conversion clock enable
    logic       cnv_rise;    // Filtered start rising edge
    logic       status_read; // Status register read this cycle
    logic [3:0] idx_m1;      // Next lower bit index
    logic [31:0] status_word; // Status register contents

    // Shared combinational helpers
    always_comb begin
        step_tick   = (cur.div_cnt == 8'(STEP_LEN - 1));
        cnv_rise    = filt(cur.cnv_sync, cur.cnv_f) && !cur.cnv_f;
        status_read = reg_rd_i && hit(reg_addr_i, sar_seq_pkg::STATUS_OFFSET);
        idx_m1      = cur.bit_idx - 4'h1;
        status_word = 32'h0000_0000;
        status_word[sar_seq_pkg::STS_OV_BIT]    = cur.ov_flag;
        status_word[sar_seq_pkg::STS_BUSY_BIT]  =
            (cur.state != sar_seq_pkg::ST_ACQUIRE);
        status_word[sar_seq_pkg::STS_SPAN_BIT]  = cur.span;
        status_word[sar_seq_pkg::STS_CLAMP_BIT] = cur.clamp_f;
    end

    // Next-state logic for the whole block
    always_comb begin
        next_cur = cur;
        next_cur.res_valid = 1'b0;

        // Pin synchronisers; stage one feeds stage two only
        next_cur.cnv_sync   = {cur.cnv_sync[1:0], conversion_start_i};
        next_cur.cmp_sync   = {cur.cmp_sync[1:0], comparator_i};
        next_cur.clamp_sync = {cur.clamp_sync[1:0], clamp_active_i};
        next_cur.cnv_f      = filt(cur.cnv_sync, cur.cnv_f);
        next_cur.cmp_f      = filt(cur.cmp_sync, cur.cmp_f);
        next_cur.clamp_f    = filt(cur.clamp_sync, cur.clamp_f);

        // Divider free-runs; restarted at each conversion start
        if (step_tick) begin
            next_cur.div_cnt = 8'h00;
        end else begin
            next_cur.div_cnt = cur.div_cnt + 8'h01;
        end

        // Sequencer
        case (cur.state)
            sar_seq_pkg::ST_ACQUIRE: begin
                if (cnv_rise) begin
                    next_cur.state   = sar_seq_pkg::ST_OPEN;
                    next_cur.div_cnt = 8'h00;
                end
            end
            sar_seq_pkg::ST_OPEN: begin
                if (step_tick) begin
                    next_cur.state     = sar_seq_pkg::ST_HOLD;
                    next_cur.ov_sample = cur.clamp_f;
                end
            end
            sar_seq_pkg::ST_HOLD: begin
                if (step_tick) begin
                    next_cur.state   = sar_seq_pkg::ST_SEARCH;
                    next_cur.trial   = sar_seq_pkg::CODE_MSB;
                    next_cur.bit_idx = 4'hF;
                end
            end
            sar_seq_pkg::ST_SEARCH: begin
                // keep or drop the bit, then try the next
                if (step_tick) begin
                    // Low comparator means the trial overshot the sample
                    if (!cur.cmp_f) begin
                        next_cur.trial[cur.bit_idx] = 1'b0;
                    end
                    if (cur.bit_idx == 4'h0) begin
                        next_cur.state = sar_seq_pkg::ST_DONE;
                    end else begin
                        next_cur.trial[idx_m1] = 1'b1;
                        next_cur.bit_idx       = idx_m1;
                    end
                end
            end
            sar_seq_pkg::ST_DONE: begin
                next_cur.state     = sar_seq_pkg::ST_ACQUIRE;
                next_cur.res_valid = 1'b1;
                if (cur.ov_sample) begin
                    next_cur.result = sar_seq_pkg::CODE_TOP;
                end else begin
                    // straight binary; search floors at 0
                    next_cur.result = cur.trial;
                end
            end
            default: begin
                next_cur.state = sar_seq_pkg::ST_ACQUIRE;
            end
        endcase

        if (reg_wr_i && hit(reg_addr_i, sar_seq_pkg::CONFIG_OFFSET)) begin
            next_cur.span = reg_wdata_i[sar_seq_pkg::CFG_SPAN_BIT];
        end

        if (status_read) begin
            next_cur.ov_flag = 1'b0;
        end
        if (cur.clamp_f) begin
            next_cur.ov_flag = 1'b1;
        end

        // Read data for the cycle after the strobe; unmapped reads zero
        next_cur.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            if (hit(reg_addr_i, sar_seq_pkg::CONFIG_OFFSET)) begin
                next_cur.rdata[sar_seq_pkg::CFG_SPAN_BIT] = cur.span;
            end else if (status_read) begin
                next_cur.rdata = status_word;
            end else if (hit(reg_addr_i, sar_seq_pkg::RESULT_OFFSET)) begin
                next_cur.rdata = {16'h0000, cur.result};
            end
        end
    end

    // State register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cur           <= '0;
            cur.state     <= sar_seq_pkg::ST_ACQUIRE;
            cur.span      <= sar_seq_pkg::SPAN_RESET;
            cur.result    <= sar_seq_pkg::RESULT_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs
    always_comb begin
        // arrays track inputs in acquisition and open phase
        sample_switch_o = (cur.state == sar_seq_pkg::ST_ACQUIRE) ||
                          (cur.state == sar_seq_pkg::ST_OPEN);
        positive_ground_switch_o = (cur.state == sar_seq_pkg::ST_ACQUIRE);
        negative_ground_switch_o = (cur.state == sar_seq_pkg::ST_ACQUIRE);
        // Array bits only carry a trial during the search
        dac_bits_o = (cur.state == sar_seq_pkg::ST_SEARCH) ?
                     cur.trial : 16'h0000;
        // front end scales range to 0.1..0.9 reference
        span_compression_o       = cur.span;
        busy_o                   = (cur.state != sar_seq_pkg::ST_ACQUIRE);
        result_o                 = cur.result;
        result_valid_o           = cur.res_valid;
        overvoltage_clamp_flag_o = cur.ov_flag;
        reg_rdata_o              = cur.rdata;
    end

    // Checks and coverage
    localparam int CONV_MAX = 1000;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_acq_connected: assert property (
        !busy_o |-> sample_switch_o && positive_ground_switch_o
                    && negative_ground_switch_o)
        else $error("arrays not tracking in acquisition");

    a_start_edge: assert property (
        !busy_o && cnv_rise |=> busy_o && sample_switch_o
                                && !positive_ground_switch_o)
        else $error("start edge did not begin conversion");

    a_ground_first: assert property (
        $fell(sample_switch_o) |-> $past(!positive_ground_switch_o)
                                   && !negative_ground_switch_o)
        else $error("arrays grounded before switches opened");

    a_msb_first: assert property (
        $rose(dac_bits_o[15]) && !$past(busy_o, 1) == 1'b0
        |-> dac_bits_o[14:0] == 15'h0000)
        else $error("search did not start at the MSB");

    a_done_valid: assert property (
        $fell(busy_o) |-> result_valid_o)
        else $error("busy ended without a result");

    a_conv_bound: assert property (
        $rose(busy_o) |-> ##[1:CONV_MAX] $fell(busy_o))
        else $error("conversion did not finish on its own");

    a_sat_high: assert property (
        result_valid_o && $past(cur.ov_sample) |-> result_o == 16'hFFFF)
        else $error("clamped input did not saturate high");

    a_flag_sticky: assert property (
        overvoltage_clamp_flag_o && !status_read |=> overvoltage_clamp_flag_o)
        else $error("clamp flag dropped without a read");

    a_flag_set: assert property (
        cur.clamp_f |=> overvoltage_clamp_flag_o)
        else $error("clamp flag not set while clamping");

    a_result_hold: assert property (
        !result_valid_o |-> $stable(result_o))
        else $error("result changed without completion");

    a_dac_idle: assert property (
        !busy_o |-> dac_bits_o == 16'h0000)
        else $error("array driven outside a conversion");

    a_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
        else $error("read data shown without a read");

    c_full_conv: cover property ($rose(busy_o) ##[1:CONV_MAX] result_valid_o);
    c_flag_clear: cover property (overvoltage_clamp_flag_o && status_read
                                  && !cur.clamp_f);
    c_ignored_start: cover property (busy_o && cnv_rise);

endmodule : sar_conversion_sequencer

`default_nettype wire

/* File: testbench/analog_front_model.sv */
// Behavioural analog front end: held sample against the array trial code
`timescale 1ns/1ps
`default_nettype none

module analog_front_model (
    input  wire logic signed [17:0] vin_i,           // Input in code steps
    input  wire logic        [15:0] dac_bits_i,      // Trial code on array
    input  wire logic               sample_switch_i, // Arrays on inputs
    output logic                    comparator_o     // 1 keeps trial bit
);
    logic signed [17:0] held; // Charge frozen once arrays leave inputs

    always_latch begin
        if (sample_switch_i) begin
            held <= vin_i;
        end
    end

    // compare held charge
    // Signed compare: over-range keeps every bit, under-range none
    assign comparator_o = (held >= $signed({2'b00, dac_bits_i}));
endmodule : analog_front_model

`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int unsigned STEP = 6;            // Step length under test
    localparam int unsigned LAT  = 18 * STEP + 1; // Busy rise to new code
    logic               mclk_i, rst_i, start, clamp, cmp, wr, rd;
    logic        [7:0]  addr;
    logic        [31:0] wdata, rdata;
    logic               smp, gpos, gneg, span, busy, valid, ovf;
    logic        [15:0] dac, result;
    logic signed [17:0] vin;
    logic signed [17:0] corners [8] = '{18'sh08000, 18'sh08001, 18'sh07FFF,
        18'sh0FFFF, 18'sh00000, 18'sh00001, 18'sh12345, -18'sd5};
    int                 num_errors, total_checks;

    sar_conversion_sequencer #(.STEP_LEN(STEP)) DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .conversion_start_i(start),
        .comparator_i(cmp), .clamp_active_i(clamp), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .sample_switch_o(smp),
        .positive_ground_switch_o(gpos), .negative_ground_switch_o(gneg),
        .dac_bits_o(dac), .span_compression_o(span), .busy_o(busy),
        .result_o(result), .result_valid_o(valid),
        .overvoltage_clamp_flag_o(ovf));

    analog_front_model front (.vin_i(vin), .dac_bits_i(dac),
        .sample_switch_i(smp), .comparator_o(cmp));

    // Free-running 125 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    // Verdict and end of run, the only exit
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // Four-state compare of any result
    task automatic check(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // Expected code: straight binary, clipped at both ends
    function automatic logic [15:0] exp_code(input logic signed [17:0] v);
        if (v > 18'sh0FFFF) return 16'hFFFF;
        if (v < 0) return 16'h0000;
        return v[15:0];
    endfunction : exp_code

    // One-cycle bus write
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : reg_write

    // One-cycle bus read, data taken in the following cycle only
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        rd <= 1'b1; addr <= a;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 check(rdata, exp, "read data");
    endtask : reg_read

    // Full conversion with a stray start edge in mid-search
    task automatic convert(input logic signed [17:0] v, input logic [15:0] e);
        int          n;
        logic [15:0] prev;
        vin <= v;
        prev = result;
        @(posedge mclk_i);
        start <= 1'b1;
        n = 0;
        while (busy !== 1'b1) begin
            @(posedge mclk_i);
            #1 n++;
            if (n > 10) begin
                check(0, 1, "busy timeout");
                close_out();
            end
        end
        // ground switches open before arrays leave inputs
        check({gpos, gneg, smp}, 3'b001, "switch order");
        n = 0;
        while (valid !== 1'b1) begin
            @(posedge mclk_i);
            if (n == 20) start <= 1'b0;
            if (n == 25) start <= 1'b1;
            #1 n++;
            if (n == 60) check(result, prev, "held code");
            if (n > 200) begin
                check(0, 1, "done timeout");
                close_out();
            end
        end
        // fixed latency with no serial clock
        check(n, LAT, "latency");
        check(result, e, "code");
        check({busy, smp}, 2'b01, "end state");
        @(posedge mclk_i);
        start <= 1'b0;
        repeat (12) @(posedge mclk_i);
        #1 check(busy, 1'b0, "stray start");
    endtask : convert

    // Main sequence
    initial begin
        int s;
        rst_i = 1'b1; start = 1'b0; clamp = 1'b0; wr = 1'b0; rd = 1'b0;
        addr = 8'h00; wdata = 32'h0; vin = 18'sh0;
        num_errors = 0; total_checks = 0;
        s = $urandom(75443);
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped place ignored and read as zero
        reg_write(8'h10, 32'hFFFFFFFF);
        reg_read(sar_seq_pkg::CONFIG_OFFSET, 32'h0);
        reg_read(sar_seq_pkg::STATUS_OFFSET, 32'h0);
        reg_read(sar_seq_pkg::RESULT_OFFSET, 32'h0);
        reg_read(8'h10, 32'h0);
        check(span, 1'b0, "span at reset");
        // Corners then random codes, span off then on
        for (int m = 0; m < 2; m++) begin
            foreach (corners[i]) convert(corners[i], exp_code(corners[i]));
            for (int i = 0; i < 4; i++) begin
                s = $urandom;
                convert($signed({2'b00, s[15:0]}), s[15:0]);
            end
            reg_write(sar_seq_pkg::CONFIG_OFFSET, 32'h1);
            #1 check(span, 1'b1, "span on");
        end
        reg_read(sar_seq_pkg::RESULT_OFFSET, {16'h0, result});
        // Clamp: live and sticky status, forced top code
        clamp <= 1'b1;
        repeat (5) @(posedge mclk_i);
        #1 check(ovf, 1'b1, "flag set");
        reg_read(sar_seq_pkg::STATUS_OFFSET, 32'hD);
        convert(18'sh01234, 16'hFFFF);
        clamp <= 1'b0;
        repeat (5) @(posedge mclk_i);
        reg_read(sar_seq_pkg::STATUS_OFFSET, 32'h5);
        reg_read(sar_seq_pkg::STATUS_OFFSET, 32'h4);
        check(ovf, 1'b0, "flag cleared");
        reg_write(sar_seq_pkg::CONFIG_OFFSET, 32'h0);
        reg_read(sar_seq_pkg::CONFIG_OFFSET, 32'h0);
        close_out();
    end
endmodule : tb

`default_nettype wire
